// ==== src/hifs_pkg.sv ====
// Constants and types for the hall input fault supervisor
// Summary of operation
// - Status released high above upper current threshold, driven low below lower one.
// - Supply above 18V cuts both feeds, drives statuses low, zeroes mirrors.
// - Supply back in range restarts both feeds, each with blanking first.
// - Short to ground removes feed current, keeps only weak 50 uA pull-up.
// - Short-to-ground fault stays latched while the input remains loaded.
// - During short to ground, status released high-Z and mirror zeroed.
// - Input above supply minus 100mV flags short to battery: status low, mirror zero.
// - After short to battery or open input, restart once loaded again.
// - Open or battery-shorted at power-up leaves status high-Z until loaded.
// - Sleep input low over 40us enters sleep: statuses high-Z, mirrors zero.
// - Sleep pulse low up to 20us restarts latched channels, with blanking, on rise.
// - Short restart pulse leaves normally operating channels untouched.
// - Latched input open for 10ms becomes open fault; reconnect restarts with blanking.
// - Leaving sleep runs a blanking period before reporting status.
package hifs_pkg;
    localparam int CLK_MHZ = 100;
    localparam int SLEEP_MIN_US = 40;
    localparam int PULSE_MAX_US = 20;
    localparam int BLANK_US = 50;
    localparam int OPEN_MS = 10;
    localparam int SLEEP_CYC = SLEEP_MIN_US * CLK_MHZ;
    localparam int PULSE_MAX_CYC = PULSE_MAX_US * CLK_MHZ;
    localparam int BLANK_CYC = BLANK_US * CLK_MHZ;
    localparam int OPEN_CYC = OPEN_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 20;
    localparam int NCH = 2;
    typedef enum logic [2:0] {
        CH_INIT, CH_BLANK, CH_RUN, CH_SHORT_GND, CH_OPEN_BAT
    } hifs_ch_t;
endpackage

// ==== src/hifs_top.sv ====
// Two-channel hall input fault and sleep supervisor
`timescale 1ns/100ps
module hifs_top #(
    parameter int BLANK_CYC = hifs_pkg::BLANK_CYC,
    parameter int OPEN_CYC = hifs_pkg::OPEN_CYC,
    parameter int SLEEP_CYC = hifs_pkg::SLEEP_CYC,
    parameter int PULSE_MAX_CYC = hifs_pkg::PULSE_MAX_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Host side
    input wire logic sleep_n,
    // Supply comparator: rail above 18V
    input wire logic supply_rail_over,
    // Per-channel analog comparators, bit 0 channel a, bit 1 channel b
    input wire logic [1:0] feed_above_high,
    input wire logic [1:0] feed_below_low,
    input wire logic [1:0] feed_short_gnd,
    input wire logic [1:0] feed_near_rail,
    input wire logic [1:0] feed_open,
    // Status pins, open drain
    output logic status_out_a_o,
    output logic status_out_a_oe,
    output logic status_out_b_o,
    output logic status_out_b_oe,
    // Analog mirror enables
    output logic current_mirror_out_a_en,
    output logic current_mirror_out_b_en,
    // Feed drive controls
    output logic [1:0] feed_supply_en,
    output logic [1:0] feed_pullup_en
);
    localparam logic [hifs_pkg::CNT_W-1:0] CNT_ONE = 20'h00001;
    // Local names for the channel states
    localparam hifs_pkg::hifs_ch_t CH_INIT = hifs_pkg::CH_INIT;
    localparam hifs_pkg::hifs_ch_t CH_BLANK = hifs_pkg::CH_BLANK;
    localparam hifs_pkg::hifs_ch_t CH_RUN = hifs_pkg::CH_RUN;
    localparam hifs_pkg::hifs_ch_t CH_SHORT_GND = hifs_pkg::CH_SHORT_GND;
    localparam hifs_pkg::hifs_ch_t CH_OPEN_BAT = hifs_pkg::CH_OPEN_BAT;

    // Sleep pulse measurement
    logic [hifs_pkg::CNT_W-1:0] low_cnt_ff, nxt_low_cnt;
    logic sleep_ff, nxt_sleep;
    logic sleep_d_ff, nxt_sleep_d;
    logic restart_pulse;
    logic wake_pulse;
    always_comb begin
        nxt_sleep_d = sleep_n;
        nxt_low_cnt = low_cnt_ff;
        nxt_sleep = sleep_ff;
        restart_pulse = 1'b0;
        wake_pulse = 1'b0;
        if (!sleep_n) begin
            if (low_cnt_ff != hifs_pkg::CNT_W'(SLEEP_CYC))
                nxt_low_cnt = low_cnt_ff + CNT_ONE;
            else
                nxt_sleep = 1'b1;
        end else begin
            nxt_low_cnt = '0;
            if (!sleep_d_ff) begin
                // Rising edge: short pulse restarts, long pulse wakes
                if (sleep_ff) begin
                    nxt_sleep = 1'b0;
                    wake_pulse = 1'b1;
                end else if (low_cnt_ff <= hifs_pkg::CNT_W'(PULSE_MAX_CYC)) begin
                    restart_pulse = 1'b1;
                end
            end
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            low_cnt_ff <= '0;
            sleep_ff <= 1'b0;
            sleep_d_ff <= 1'b1;
        end else begin
            low_cnt_ff <= nxt_low_cnt;
            sleep_ff <= nxt_sleep;
            sleep_d_ff <= nxt_sleep_d;
        end
    end

    // Over-voltage tracking for restart on return
    logic ov_ff, nxt_ov;
    logic ov_release;
    always_comb begin
        nxt_ov = supply_rail_over;
        ov_release = ov_ff && !supply_rail_over;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            ov_ff <= 1'b0;
        else
            ov_ff <= nxt_ov;
    end

    // Per-channel state machines
    hifs_pkg::hifs_ch_t st_ff [hifs_pkg::NCH];
    logic [hifs_pkg::CNT_W-1:0] cnt_ff [hifs_pkg::NCH];
    logic [1:0] level_ff;
    logic [1:0] pwrup_ff;
    logic [1:0] drive_low_ff, mir_ff, sup_ff, pu_ff;
    genvar g;
    generate
        for (g = 0; g < hifs_pkg::NCH; g++) begin : gen_ch
            hifs_pkg::hifs_ch_t nxt_st;
            logic [hifs_pkg::CNT_W-1:0] nxt_cnt;
            logic nxt_level, nxt_pwrup, nxt_low, nxt_mir, nxt_sup, nxt_pu;
            always_comb begin
                nxt_st = st_ff[g];
                nxt_cnt = cnt_ff[g];
                nxt_level = level_ff[g];
                nxt_pwrup = pwrup_ff[g];
                unique case (st_ff[g])
                    CH_INIT: begin
                        if (feed_open[g] || feed_near_rail[g]) begin
                            nxt_st = CH_OPEN_BAT;
                        end else begin
                            nxt_st = CH_BLANK;
                            nxt_cnt = '0;
                        end
                    end
                    CH_BLANK: begin
                        // Short detection masked while blanking
                        if (cnt_ff[g] == hifs_pkg::CNT_W'(BLANK_CYC - 1)) begin
                            nxt_st = CH_RUN;
                            nxt_pwrup = 1'b0;
                            nxt_level = feed_above_high[g];
                        end else begin
                            nxt_cnt = cnt_ff[g] + CNT_ONE;
                        end
                    end
                    CH_RUN: begin
                        if (feed_short_gnd[g]) begin
                            nxt_st = CH_SHORT_GND;
                            nxt_cnt = '0;
                        end else if (feed_near_rail[g] || feed_open[g]) begin
                            nxt_st = CH_OPEN_BAT;
                        end else if (feed_above_high[g]) begin
                            nxt_level = 1'b1;
                        end else if (feed_below_low[g]) begin
                            nxt_level = 1'b0;
                        end
                    end
                    CH_SHORT_GND: begin
                        // Latched while loaded; open for the window ends it
                        if (restart_pulse) begin
                            nxt_st = CH_BLANK;
                            nxt_cnt = '0;
                        end else if (feed_open[g]) begin
                            if (cnt_ff[g] == hifs_pkg::CNT_W'(OPEN_CYC - 1))
                                nxt_st = CH_OPEN_BAT;
                            else
                                nxt_cnt = cnt_ff[g] + CNT_ONE;
                        end else begin
                            nxt_cnt = '0;
                        end
                    end
                    CH_OPEN_BAT: begin
                        if (!feed_open[g] && !feed_near_rail[g]) begin
                            nxt_st = CH_BLANK;
                            nxt_cnt = '0;
                        end
                    end
                    default: nxt_st = CH_INIT;
                endcase
                // Over-voltage and sleep override, restart on exit
                // Wake outranks the sleep hold in its single cycle
                if (supply_rail_over || (sleep_ff && !wake_pulse)) begin
                    nxt_st = CH_INIT;
                end else if (ov_release || wake_pulse) begin
                    nxt_st = CH_BLANK;
                    nxt_cnt = '0;
                end
                nxt_sup = 1'b0;
                nxt_pu = 1'b0;
                nxt_mir = 1'b0;
                nxt_low = 1'b0;
                unique case (nxt_st)
                    CH_BLANK: begin
                        nxt_sup = 1'b1;
                        nxt_low = 1'b1;
                    end
                    CH_RUN: begin
                        nxt_sup = 1'b1;
                        nxt_mir = 1'b1;
                        nxt_low = !nxt_level;
                    end
                    CH_SHORT_GND: begin
                        nxt_pu = 1'b1;
                        nxt_low = 1'b0;
                    end
                    CH_OPEN_BAT: begin
                        nxt_sup = 1'b1;
                        nxt_low = !nxt_pwrup;
                    end
                    default: begin
                        nxt_sup = 1'b0;
                    end
                endcase
                // Over-voltage pulls the status low; sleep releases it
                if (supply_rail_over) begin
                    nxt_low = 1'b1;
                end else if (sleep_ff && !wake_pulse) begin
                    nxt_low = 1'b0;
                    nxt_mir = 1'b0;
                end
            end
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    st_ff[g] <= CH_INIT;
                    cnt_ff[g] <= '0;
                    level_ff[g] <= 1'b0;
                    pwrup_ff[g] <= 1'b1;
                    drive_low_ff[g] <= 1'b0;
                    mir_ff[g] <= 1'b0;
                    sup_ff[g] <= 1'b0;
                    pu_ff[g] <= 1'b0;
                end else begin
                    st_ff[g] <= nxt_st;
                    cnt_ff[g] <= nxt_cnt;
                    level_ff[g] <= nxt_level;
                    pwrup_ff[g] <= nxt_pwrup;
                    drive_low_ff[g] <= nxt_low;
                    mir_ff[g] <= nxt_mir;
                    sup_ff[g] <= nxt_sup;
                    pu_ff[g] <= nxt_pu;
                end
            end
            // Checks per channel
            a_short_releases: assert property (@(posedge core_clk) disable iff (rst)
                st_ff[g] == CH_SHORT_GND |-> !drive_low_ff[g] && !mir_ff[g] && !sup_ff[g]
                    && pu_ff[g])
                else $error("short fault outputs wrong");
            a_ov_cuts_feed: assert property (@(posedge core_clk) disable iff (rst)
                supply_rail_over |=> !sup_ff[g] && drive_low_ff[g] && !mir_ff[g])
                else $error("over-voltage did not cut feed");
            a_short_latched: assert property (@(posedge core_clk) disable iff (rst)
                st_ff[g] == CH_SHORT_GND && !feed_open[g] && !restart_pulse
                    && !supply_rail_over && !sleep_ff |=> st_ff[g] == CH_SHORT_GND)
                else $error("short fault not held");
            a_rail_short: assert property (@(posedge core_clk) disable iff (rst)
                st_ff[g] == CH_RUN && feed_near_rail[g] && !feed_short_gnd[g]
                    && !supply_rail_over && !sleep_ff |=> drive_low_ff[g] && !mir_ff[g])
                else $error("rail short not reported");
            a_run_untouched: assert property (@(posedge core_clk) disable iff (rst)
                st_ff[g] == CH_RUN && restart_pulse && !feed_short_gnd[g]
                    && !feed_near_rail[g] && !feed_open[g] && !supply_rail_over
                    |=> st_ff[g] == CH_RUN)
                else $error("restart disturbed running channel");
            a_blank_no_short: assert property (@(posedge core_clk) disable iff (rst)
                st_ff[g] == CH_BLANK && $past(st_ff[g]) == CH_BLANK |-> drive_low_ff[g])
                else $error("status not held during blanking");
            a_reload_blanks: assert property (@(posedge core_clk) disable iff (rst)
                st_ff[g] == CH_OPEN_BAT && !feed_open[g] && !feed_near_rail[g]
                    && !supply_rail_over && !sleep_ff |=> st_ff[g] == CH_BLANK)
                else $error("reload did not restart");
            a_level_high: assert property (@(posedge core_clk) disable iff (rst)
                st_ff[g] == CH_RUN && feed_above_high[g] && !feed_short_gnd[g]
                    && !feed_near_rail[g] && !feed_open[g] && !supply_rail_over && !sleep_ff
                    |=> !drive_low_ff[g] && mir_ff[g])
                else $error("high current not reported");
            a_restart_blanks: assert property (@(posedge core_clk) disable iff (rst)
                st_ff[g] == CH_SHORT_GND && restart_pulse && !supply_rail_over
                    |=> st_ff[g] == CH_BLANK)
                else $error("restart pulse did not blank");
            a_blank_masks: assert property (@(posedge core_clk) disable iff (rst)
                st_ff[g] == CH_BLANK && feed_short_gnd[g] && !supply_rail_over && !sleep_ff
                    |=> st_ff[g] != CH_SHORT_GND)
                else $error("short seen during blanking");
            a_open_timeout: assert property (@(posedge core_clk) disable iff (rst)
                st_ff[g] == CH_SHORT_GND && feed_open[g] && !restart_pulse
                    && cnt_ff[g] == hifs_pkg::CNT_W'(OPEN_CYC - 1) && !supply_rail_over
                    && !sleep_ff |=> st_ff[g] == CH_OPEN_BAT)
                else $error("open input not registered");
            a_powerup_hiz: assert property (@(posedge core_clk) disable iff (rst)
                st_ff[g] == CH_OPEN_BAT && pwrup_ff[g] |-> !drive_low_ff[g])
                else $error("power-up open input driven");
            c_short_seen: cover property (@(posedge core_clk) st_ff[g] == CH_SHORT_GND);
            c_restart_seen: cover property (@(posedge core_clk)
                st_ff[g] == CH_SHORT_GND ##1 st_ff[g] == CH_BLANK);
        end
    endgenerate

    a_sleep_release: assert property (@(posedge core_clk) disable iff (rst)
        sleep_ff && !wake_pulse && !supply_rail_over
            |=> status_out_a_oe == 1'b0 && status_out_b_oe == 1'b0
            && !current_mirror_out_a_en && !current_mirror_out_b_en)
        else $error("sleep outputs not released");
    a_wake_blanks: assert property (@(posedge core_clk) disable iff (rst)
        wake_pulse && !supply_rail_over |=> st_ff[0] == CH_BLANK && st_ff[1] == CH_BLANK)
        else $error("wake without blanking");
    c_sleep_seen: cover property (@(posedge core_clk) sleep_ff);
    c_wake_seen: cover property (@(posedge core_clk) wake_pulse);
    c_ov_seen: cover property (@(posedge core_clk) ov_release);

    // Pin drive from registers
    always_comb begin
        status_out_a_o = 1'b0;
        status_out_b_o = 1'b0;
        status_out_a_oe = drive_low_ff[0];
        status_out_b_oe = drive_low_ff[1];
        current_mirror_out_a_en = mir_ff[0];
        current_mirror_out_b_en = mir_ff[1];
        feed_supply_en = sup_ff;
        feed_pullup_en = pu_ff;
    end
endmodule

// ==== verification/hifs_sensor_model.sv ====
// Behavioural model of the two sensors and their comparator front end
`timescale 1ns/100ps
module hifs_sensor_model (
    // Per channel: 0 low, 1 high, 2 short, 3 open, 4 near rail, 5 between
    input wire logic [2:0] mode_a,
    input wire logic [2:0] mode_b,
    // Feed drive from the supervisor
    input wire logic [1:0] feed_supply_en,
    // Comparator levels, bit 0 channel a
    output logic [1:0] feed_above_high,
    output logic [1:0] feed_below_low,
    output logic [1:0] feed_short_gnd,
    output logic [1:0] feed_near_rail,
    output logic [1:0] feed_open
);
    logic [2:0] md [2];

    // Sensor current only flows while its feed is powered
    always_comb begin
        md[0] = mode_a;
        md[1] = mode_b;
        for (int i = 0; i < 2; i++) begin
            feed_above_high[i] = feed_supply_en[i] && md[i] == 3'h1;
            feed_below_low[i] = feed_supply_en[i] && md[i] == 3'h0;
            feed_short_gnd[i] = md[i] == 3'h2;
            feed_open[i] = md[i] == 3'h3; // Pull-up lifts an unloaded input
            feed_near_rail[i] = md[i] == 3'h4;
        end
    end
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the hall input fault supervisor
`timescale 1ns/100ps
module tb_top;
    logic core_clk, rst, sleep_n, supply_rail_over;
    logic [2:0] mode_a, mode_b;
    logic [1:0] above, below, shrt, near, opn, sup, pu;
    logic oa, ob, oea, oeb, ma, mb;
    logic [7:0] obs;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;

    // Observed outputs packed: oe a, oe b, mirror a, mirror b, supply, pull-up
    assign obs = {oea, oeb, ma, mb, sup, pu};

    hifs_top #(.BLANK_CYC(10), .OPEN_CYC(20), .SLEEP_CYC(8), .PULSE_MAX_CYC(4)) dut_u (
        .core_clk(core_clk), .rst(rst), .sleep_n(sleep_n),
        .supply_rail_over(supply_rail_over), .feed_above_high(above),
        .feed_below_low(below), .feed_short_gnd(shrt), .feed_near_rail(near),
        .feed_open(opn), .status_out_a_o(oa), .status_out_a_oe(oea),
        .status_out_b_o(ob), .status_out_b_oe(oeb), .current_mirror_out_a_en(ma),
        .current_mirror_out_b_en(mb), .feed_supply_en(sup), .feed_pullup_en(pu));

    hifs_sensor_model sensors_u (
        .mode_a(mode_a), .mode_b(mode_b), .feed_supply_en(sup),
        .feed_above_high(above), .feed_below_low(below), .feed_short_gnd(shrt),
        .feed_near_rail(near), .feed_open(opn));

    // Clock generator
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic setm(input logic [2:0] a, input logic [2:0] b);
        @(posedge core_clk);
        mode_a <= a;
        mode_b <= b;
    endtask

    task automatic t_powerup();
        wt(3);
        chk(obs, 8'h8C);
        chk({6'h00, oa, ob}, 8'h00);
        wt(15);
        chk(obs, 8'h2C);
        setm(3'h1, 3'h0);
        wt(3);
        chk(obs, 8'h6C);
        wt(15);
        chk(obs, 8'h7C);
        $display("power-up test done");
    endtask

    task automatic t_hyst();
        setm(3'h5, 3'h0);
        wt(3);
        chk(obs, 8'h7C);
        setm(3'h0, 3'h0);
        wt(3);
        chk(obs, 8'hFC);
        setm(3'h5, 3'h0);
        wt(3);
        chk(obs, 8'hFC);
        setm(3'h1, 3'h0);
        wt(3);
        chk(obs, 8'h7C);
        $display("hysteresis test done");
    endtask

    task automatic t_short_restart();
        setm(3'h2, 3'h0);
        wt(3);
        chk(obs, 8'h59);
        setm(3'h1, 3'h0);
        wt(20);
        chk(obs, 8'h59);
        // Short low pulse on the sleep input, within the restart window
        @(posedge core_clk);
        sleep_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        sleep_n <= 1'b1;
        wt(3);
        chk(obs, 8'hDC);
        wt(15);
        chk(obs, 8'h7C);
        $display("short and restart test done");
    endtask

    task automatic t_battery();
        setm(3'h1, 3'h4);
        wt(3);
        chk(obs, 8'h6C);
        setm(3'h1, 3'h0);
        wt(3);
        chk(obs, 8'h6C);
        wt(15);
        chk(obs, 8'h7C);
        $display("battery short test done");
    endtask

    task automatic t_open_reload();
        setm(3'h2, 3'h0);
        wt(3);
        chk(obs, 8'h59);
        setm(3'h3, 3'h0);
        wt(12);
        chk(obs, 8'h59);
        wt(15);
        chk(obs, 8'hDC);
        setm(3'h1, 3'h0);
        wt(3);
        chk(obs, 8'hDC);
        wt(15);
        chk(obs, 8'h7C);
        $display("open reload test done");
    endtask

    task automatic t_overvolt();
        @(posedge core_clk);
        supply_rail_over <= 1'b1;
        wt(3);
        chk(obs, 8'hC0);
        @(posedge core_clk);
        supply_rail_over <= 1'b0;
        wt(3);
        chk(obs, 8'hCC);
        wt(15);
        chk(obs, 8'h7C);
        $display("over-voltage test done");
    endtask

    task automatic t_sleep();
        @(posedge core_clk);
        sleep_n <= 1'b0;
        wt(12);
        chk({obs[7:4], 4'h0}, 8'h00);
        @(posedge core_clk);
        sleep_n <= 1'b1;
        wt(3);
        chk(obs, 8'hCC);
        wt(15);
        chk(obs, 8'h7C);
        $display("sleep test done");
    endtask

    task automatic t_blank_mask();
        @(posedge core_clk);
        supply_rail_over <= 1'b1;
        wt(2);
        // Short appears as the restart blanking begins
        @(posedge core_clk);
        supply_rail_over <= 1'b0;
        mode_a <= 3'h2;
        wt(5);
        chk(obs, 8'hCC);
        setm(3'h1, 3'h0);
        wt(15);
        chk(obs, 8'h7C);
        $display("blanking mask test done");
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        sleep_n = 1'b1;
        supply_rail_over = 1'b0;
        mode_a = 3'h1;
        mode_b = 3'h3;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        t_powerup();
        t_hyst();
        t_short_restart();
        t_battery();
        t_open_reload();
        t_overvolt();
        t_sleep();
        t_blank_mask();
        close_out();
    end
endmodule
